// ### common/clkgen_defines.vh
// Constants for the system clock generator: register address, field
// positions, reset values and timing counts.
// Assumes a 100 MHz i_mclk; every count below is derived from that rate.
`ifndef CLKGEN_DEFINES_VH
`define CLKGEN_DEFINES_VH

// Register map
`define CLKGEN_PIN_MODE_ADDR 16'hff9f
`define CLKGEN_PIN_MODE_RST 8'h00
`define CLKGEN_PIN_MODE_WMASK 8'hc1

// Field positions of the pin mode register
`define CLKGEN_BIT_EXT_INPUT 7
`define CLKGEN_BIT_OSC_SEL 6
`define CLKGEN_BIT_AMP_HIGH 0

// Clock rates in kHz
`define CLKGEN_MCLK_KHZ 100000
`define CLKGEN_FAST_INT_KHZ 16000
`define CLKGEN_SLOW_INT_KHZ 240
`define CLKGEN_AMP_SWITCH_KHZ 10000

// Multiplier ratios
`define CLKGEN_MULT_LOW 8
`define CLKGEN_MULT_HIGH 12

// CPU clock hold after raising the gain bit, least time in ns
`define CLKGEN_AMP_HOLD_NS 5000
`define CLKGEN_MCLK_PERIOD_NS 10
`define CLKGEN_AMP_HOLD_CYC \
  ((`CLKGEN_AMP_HOLD_NS + `CLKGEN_MCLK_PERIOD_NS - 1) / `CLKGEN_MCLK_PERIOD_NS)

// Divider counts that model the internal oscillators (rounded to nearest)
`define CLKGEN_FAST_DIV \
  ((`CLKGEN_MCLK_KHZ + `CLKGEN_FAST_INT_KHZ / 2) / `CLKGEN_FAST_INT_KHZ)
`define CLKGEN_SLOW_DIV \
  ((`CLKGEN_MCLK_KHZ + `CLKGEN_SLOW_INT_KHZ / 2) / `CLKGEN_SLOW_INT_KHZ)

`endif

// ### src/clkgen_sync.v
// Two flip-flop synchroniser for a group of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherence is given.
`default_nettype none

module clkgen_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // Levels in and out
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  ////////////////////////////////////////////////////////////////////////
  // One chain per bit; only the second stage is visible outside
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_r; // First stage, read by the second only
      reg stable_r; // Second stage
      always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          meta_r <= 1'b0;
          stable_r <= 1'b0;
        end else begin
          meta_r <= i_async[g];
          stable_r <= meta_r;
        end
      end
      assign o_sync[g] = stable_r;
    end
  endgenerate

endmodule // clkgen_sync

`default_nettype wire

// ### src/clkgen_tick_div.v
// Divider that models a free oscillator as a one-cycle tick on i_mclk.
// Assumes i_run is a same-domain level; stopping clears the phase.
`default_nettype none

module clkgen_tick_div #(
  parameter DIV = 6,
  parameter CW = 10
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // Control and output
  input wire i_run,
  output reg o_tick
);

  reg [CW-1:0] cnt_r; // Cycles since last tick
  localparam integer LAST_INT = DIV - 1; // Full-width count before the cut
  localparam [CW-1:0] LAST = LAST_INT[CW-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Count while running; a stopped oscillator emits nothing
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= {CW{1'b0}};
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_r <= {CW{1'b0}};
      o_tick <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r <= {CW{1'b0}};
      o_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      o_tick <= 1'b0;
    end
  end

endmodule // clkgen_tick_div

`default_nettype wire

// ### src/clkgen_top.v
// System clock generator: pin mode register, shared clock pins, main
// clock selection, internal oscillator models and the USB multiplier.
// Assumes the CPU drives a same-clock special register access port and
// the control levels of the other clock registers; pins are asynchronous.
`default_nettype none
`include "clkgen_defines.vh"

module clkgen_top #(
  parameter PHASE_W = 16,
  parameter HOLD_W = 10
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // Special register access port
  input wire [15:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  // Control levels from the other clock registers and the CPU
  input wire i_stop_instr,
  input wire i_main_osc_halt,
  input wire i_int_osc_stop,
  input wire i_slow_osc_stop,
  input wire i_opt_slow_stop_en,
  input wire i_main_clock_sel,
  input wire i_mult_ratio_select,
  input wire i_mult_halt,
  input wire i_tmr_sel_slow,
  // Port block side of the shared pins
  input wire i_shared_pin_a_dir,
  input wire i_shared_pin_a_port,
  input wire i_shared_pin_b_dir,
  input wire i_shared_pin_b_port,
  // Shared pin pads
  input wire i_resonator_in_pin,
  output reg o_resonator_in_pin,
  output reg o_resonator_in_pin_oe,
  input wire i_resonator_out_pin,
  output reg o_resonator_out_pin,
  output reg o_resonator_out_pin_oe,
  // Pin levels seen by the port block
  output wire [1:0] o_port_pin_lvl,
  // Clock outputs as one-cycle ticks
  output reg o_cpu_tick,
  output reg o_main_tick,
  output reg o_hs_tick,
  output reg o_wdt_tick,
  output reg o_tmr_tick,
  // Status
  output reg o_amp_gain_high,
  output reg o_cpu_hold,
  output reg o_mult_run,
  output reg [PHASE_W-1:0] o_usb_phase
);

  ////////////////////////////////////////////////////////////////////////
  // Mode encodings of the two select bits
  localparam [1:0] MODE_PORT0 = 2'b00;
  localparam [1:0] MODE_RESON = 2'b01;
  localparam [1:0] MODE_PORT1 = 2'b10;
  localparam [1:0] MODE_EXTIN = 2'b11;
  // Counts are integers first, then cut to the register widths on purpose
  localparam integer HOLD_INT = `CLKGEN_AMP_HOLD_CYC;
  localparam integer MULT_LO_INT = `CLKGEN_MULT_LOW;
  localparam integer MULT_HI_INT = `CLKGEN_MULT_HIGH;
  localparam [HOLD_W-1:0] HOLD_CYC = HOLD_INT[HOLD_W-1:0];
  localparam [PHASE_W-1:0] MULT_LO = MULT_LO_INT[PHASE_W-1:0];
  localparam [PHASE_W-1:0] MULT_HI = MULT_HI_INT[PHASE_W-1:0];

  // Pin mode register fields
  reg ext_input_select_r; // Bit 7
  reg osc_select_r; // Bit 6
  reg amp_gain_high_r; // Bit 0
  reg [7:0] clock_pin_mode_reg; // Assembled read view

  // Decoded pin modes
  reg [1:0] pin_mode;
  reg reson_mode;
  reg extin_mode;

  // Synchronised pads and edge history
  wire [1:0] pin_sync;
  reg [1:0] pin_prev_r;
  wire a_rise;
  wire b_rise;

  // Internal oscillator ticks
  wire fast_tick;
  wire slow_tick;
  wire fast_run;
  wire slow_run;

  // High-speed source gating and main clock
  wire hs_enable;
  reg hs_tick_nxt;
  reg main_sel_r;
  reg main_tick_nxt;

  // Gain hold counter
  reg [HOLD_W-1:0] hold_cnt_r;
  wire reg_hit;
  wire amp_rise;

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  assign reg_hit = (i_addr == `CLKGEN_PIN_MODE_ADDR);
  assign amp_rise = reg_hit && i_wr && i_wdata[`CLKGEN_BIT_AMP_HIGH] && !amp_gain_high_r;

  // Pin mode register; only bits 7, 6 and 0 hold state
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ext_input_select_r <= 1'b0;
      osc_select_r <= 1'b0;
      amp_gain_high_r <= 1'b0;
    end else if (reg_hit && i_wr) begin
      // Mode bits follow each write; software changes them only while
      // the main oscillator is halted, so no glitch guard is needed here
      ext_input_select_r <= i_wdata[`CLKGEN_BIT_EXT_INPUT];
      osc_select_r <= i_wdata[`CLKGEN_BIT_OSC_SEL];
      amp_gain_high_r <= i_wdata[`CLKGEN_BIT_AMP_HIGH];
    end
  end

  // Read view; reserved bits are constant zero
  always @* begin
    clock_pin_mode_reg = 8'h00;
    clock_pin_mode_reg[`CLKGEN_BIT_EXT_INPUT] = ext_input_select_r;
    clock_pin_mode_reg[`CLKGEN_BIT_OSC_SEL] = osc_select_r;
    clock_pin_mode_reg[`CLKGEN_BIT_AMP_HIGH] = amp_gain_high_r;
  end

  // Read data is registered; unmapped addresses read zero
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd && reg_hit) begin
      o_rdata <= clock_pin_mode_reg & `CLKGEN_PIN_MODE_WMASK;
    end else if (i_rd) begin
      o_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin mode decode
  always @* begin
    pin_mode = {ext_input_select_r, osc_select_r};
    case (pin_mode)
      MODE_RESON: begin
        reson_mode = 1'b1;
        extin_mode = 1'b0;
      end
      MODE_EXTIN: begin
        reson_mode = 1'b0;
        extin_mode = 1'b1;
      end
      MODE_PORT0, MODE_PORT1: begin
        reson_mode = 1'b0;
        extin_mode = 1'b0;
      end
      default: begin
        reson_mode = 1'b0;
        extin_mode = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Pad drive. In port mode the port direction (0 = output) and latch
  // steer the pad. In resonator mode those settings are ignored; in external clock mode only the second pin ignores them.
  always @* begin
    if (reson_mode) begin
      // Resonator pins: the amplifier drives the second pin inverted
      o_resonator_in_pin = 1'b0;
      o_resonator_in_pin_oe = 1'b0;
      o_resonator_out_pin = !pin_sync[0];
      o_resonator_out_pin_oe = !i_main_osc_halt && !i_stop_instr;
    end else if (extin_mode) begin
      // First pin stays a port, second pin is a clock input
      o_resonator_in_pin = i_shared_pin_a_port;
      o_resonator_in_pin_oe = !i_shared_pin_a_dir;
      o_resonator_out_pin = 1'b0;
      o_resonator_out_pin_oe = 1'b0;
    end else begin
      o_resonator_in_pin = i_shared_pin_a_port;
      o_resonator_in_pin_oe = !i_shared_pin_a_dir;
      o_resonator_out_pin = i_shared_pin_b_port;
      o_resonator_out_pin_oe = !i_shared_pin_b_dir;
    end
  end

  // Pads cross into the clock domain before anything reads them
  clkgen_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_resonator_out_pin, i_resonator_in_pin}),
    .o_sync(pin_sync)
  );

  assign o_port_pin_lvl = pin_sync;

  // Edge history for the clock pins
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pin_prev_r <= 2'b00;
    end else begin
      pin_prev_r <= pin_sync;
    end
  end

  assign a_rise = pin_sync[0] && !pin_prev_r[0];
  assign b_rise = pin_sync[1] && !pin_prev_r[1];

  ////////////////////////////////////////////////////////////////////////
  // High-speed system clock. Both sources stop on STOP or the halt bit.
  // A 12 or 16 MHz pin clock is sampled at 100 MHz, so each edge is seen.
  assign hs_enable = !i_stop_instr && !i_main_osc_halt;

  always @* begin
    if (!hs_enable) begin
      hs_tick_nxt = 1'b0;
    end else if (reson_mode) begin
      hs_tick_nxt = a_rise;
    end else if (extin_mode) begin
      hs_tick_nxt = b_rise;
    end else begin
      hs_tick_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal oscillators
  assign fast_run = !i_stop_instr && !i_int_osc_stop;
  // The slow stop request only counts when the option byte allows it
  assign slow_run = !(i_opt_slow_stop_en && i_slow_osc_stop);

  clkgen_tick_div #(
    .DIV(`CLKGEN_FAST_DIV),
    .CW(4)
  ) u_fast_osc (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_run(fast_run),
    .o_tick(fast_tick)
  );

  clkgen_tick_div #(
    .DIV(`CLKGEN_SLOW_DIV),
    .CW(10)
  ) u_slow_osc (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_run(slow_run),
    .o_tick(slow_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Main clock select; reset forces the internal fast clock so the CPU
  // always starts from it
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      main_sel_r <= 1'b0;
    end else begin
      main_sel_r <= i_main_clock_sel;
    end
  end

  always @* begin
    if (main_sel_r) begin
      main_tick_nxt = hs_tick_nxt;
    end else begin
      main_tick_nxt = fast_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gain hold: raising the gain bit stops the CPU clock for a while, so
  // the oscillator can settle at the new bias before code runs again
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      hold_cnt_r <= {HOLD_W{1'b0}};
    end else if (amp_rise) begin
      hold_cnt_r <= HOLD_CYC;
    end else if (hold_cnt_r != {HOLD_W{1'b0}}) begin
      hold_cnt_r <= hold_cnt_r - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered clock and status outputs
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_hs_tick <= 1'b0;
      o_main_tick <= 1'b0;
      o_cpu_tick <= 1'b0;
      o_wdt_tick <= 1'b0;
      o_tmr_tick <= 1'b0;
      o_amp_gain_high <= 1'b0;
      o_cpu_hold <= 1'b0;
    end else begin
      o_hs_tick <= hs_tick_nxt;
      o_main_tick <= main_tick_nxt;
      // The slow clock never reaches the CPU path
      o_cpu_tick <= main_tick_nxt && !amp_rise && (hold_cnt_r <= 1);
      o_wdt_tick <= slow_tick;
      o_tmr_tick <= slow_tick && i_tmr_sel_slow;
      o_amp_gain_high <= amp_gain_high_r;
      o_cpu_hold <= amp_rise || (hold_cnt_r > 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // USB multiplier modelled as a phase accumulator: each high-speed
  // edge advances the phase by the ratio, giving 8 or 12 output periods
  // per reference period. Stopping it clears the phase.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_mult_run <= 1'b0;
      o_usb_phase <= {PHASE_W{1'b0}};
    end else if (i_mult_halt) begin
      o_mult_run <= 1'b0;
      o_usb_phase <= {PHASE_W{1'b0}};
    end else begin
      o_mult_run <= 1'b1;
      if (hs_tick_nxt) begin
        // Ratio bit: 0 selects x8, 1 selects x12
        o_usb_phase <= o_usb_phase + (i_mult_ratio_select ? MULT_HI : MULT_LO);
      end
    end
  end

endmodule // clkgen_top

`default_nettype wire

// ### bench/clkgen_properties.sv
// Checker bound to the clock generator top; it sees only its ports.
// Assumes one clock, i_mclk, and an asynchronous active-high reset.
`default_nettype none
`include "clkgen_defines.vh"
module clkgen_props #(parameter PHASE_W = 16) (
  input wire logic i_mclk, i_rst, i_wr, i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata, o_rdata,
  input wire logic i_stop_instr, i_main_osc_halt, i_mult_ratio_select,
  input wire logic i_opt_slow_stop_en, i_slow_osc_stop,
  input wire logic i_shared_pin_a_dir, i_shared_pin_b_dir,
  input wire logic o_resonator_in_pin_oe, o_resonator_out_pin_oe,
  input wire logic o_cpu_tick, o_main_tick, o_hs_tick, o_wdt_tick,
  input wire logic o_amp_gain_high, o_cpu_hold, o_mult_run,
  input wire logic [PHASE_W-1:0] o_usb_phase
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic [1:0] mode_r; // Mirror of the two mode bits
  logic [9:0] hold_r; // Cycles in the current CPU hold
  logic [9:0] gap_r; // Cycles since the last slow tick
  wire logic hit = i_wr && i_addr == `CLKGEN_PIN_MODE_ADDR;
  //////////////////////////////////////////////////////////////////
  // Mirrors; the gap restarts while the slow clock is legally stopped
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= 2'h0;
      hold_r <= 10'h000;
      gap_r <= 10'h000;
    end else begin
      if (hit) mode_r <= i_wdata[7:6];
      hold_r <= o_cpu_hold ? hold_r + 10'h001 : 10'h000;
      gap_r <= (o_wdt_tick || (i_slow_osc_stop && i_opt_slow_stop_en)) ? 10'h000
                                                                     : gap_r + 10'h001;
    end
  end
  //////////////////////////////////////////////////////////////////
  chk_gain_follow:
    assert property (hit |-> ##2 o_amp_gain_high == $past(i_wdata[0], 2)) else $error("gain bit");
  chk_hold_start:
    assert property (hit && i_wdata[0] && !o_amp_gain_high |=> o_cpu_hold) else $error("no hold");
  chk_hold_length:
    assert property ($fell(o_cpu_hold) |-> hold_r == `CLKGEN_AMP_HOLD_CYC) else $error("hold len");
  chk_hold_quiet:
    assert property (o_cpu_hold |-> !o_cpu_tick) else $error("tick in hold");
  chk_cpu_main:
    assert property (o_cpu_tick |-> o_main_tick) else $error("cpu tick source");
  chk_port_oe:
    assert property (!mode_r[0] |-> o_resonator_in_pin_oe == !i_shared_pin_a_dir
      && o_resonator_out_pin_oe == !i_shared_pin_b_dir) else $error("port oe");
  chk_reson_pin:
    assert property (mode_r == 2'h1 |-> !o_resonator_in_pin_oe) else $error("reson oe");
  chk_ext_pins:
    assert property (mode_r == 2'h3 |-> !o_resonator_out_pin_oe
      && o_resonator_in_pin_oe == !i_shared_pin_a_dir) else $error("ext oe");
  chk_halt_quiet:
    assert property ((i_main_osc_halt || i_stop_instr) [*6] |-> !o_hs_tick) else $error("hs tick");
  chk_usb_step:
    assert property (o_hs_tick && o_mult_run && $past(o_mult_run) |-> o_usb_phase ==
      PHASE_W'($past(o_usb_phase) + ($past(i_mult_ratio_select) ? 12 : 8))) else $error("usb");
  chk_slow_alive:
    assert property (!i_opt_slow_stop_en |-> gap_r < 10'h1ae) else $error("slow stalled");
  chk_read_rsvd:
    assert property (i_rd |=> o_rdata[5:1] == 5'h00) else $error("reserved bits");
endmodule // clkgen_props
`default_nettype wire

// ### bench/clkgen_xtal_model.sv
// Off-chip clock source: a resonator on pin a or a clock on pin b.
// Assumes the bench resolves each pad from this and the device drive.
`default_nettype none
module clkgen_xtal_model #(parameter int HALF_NS = 42) (
  input wire logic i_run_a, // Resonator swings pin a
  input wire logic i_run_b, // External clock on pin b
  output logic o_pad_a,
  output logic o_pad_b
);
  timeunit 1ns;
  timeprecision 100ps;
  logic osc = 1'b0; // About 12 MHz, inside the allowed range
  always #(HALF_NS) osc = ~osc;
  // Idle pads stand low so no stale edge reaches the device
  assign o_pad_a = i_run_a & osc;
  assign o_pad_b = i_run_b & osc;
endmodule // clkgen_xtal_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the clock generator top.
// Assumes common/ is on the include path; the source model sits on the pads.
`default_nettype none
`include "clkgen_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] PM = `CLKGEN_PIN_MODE_ADDR;
  logic i_mclk = 1'b0;
  logic i_rst, i_wr, i_rd, i_stop_instr, i_main_osc_halt, i_int_osc_stop;
  logic i_slow_osc_stop, i_opt_slow_stop_en, i_main_clock_sel;
  logic i_mult_ratio_select, i_mult_halt, i_tmr_sel_slow;
  logic i_shared_pin_a_dir, i_shared_pin_a_port, i_shared_pin_b_dir, i_shared_pin_b_port;
  logic [15:0] i_addr, o_usb_phase;
  logic [7:0] i_wdata, o_rdata;
  wire logic i_resonator_in_pin, i_resonator_out_pin;
  logic o_resonator_in_pin, o_resonator_in_pin_oe, o_resonator_out_pin, o_resonator_out_pin_oe;
  logic [1:0] o_port_pin_lvl;
  logic o_cpu_tick, o_main_tick, o_hs_tick, o_wdt_tick, o_tmr_tick;
  logic o_amp_gain_high, o_cpu_hold, o_mult_run;
  logic run_a, run_b, src_a, src_b;
  int fail_count, check_count, cyc, c_hs, c_cpu, c_wdt, c_tmr, c_hold, c_ph, c_main;
  // A pad is the device drive when enabled, else the off-chip source
  assign i_resonator_in_pin = o_resonator_in_pin_oe ? o_resonator_in_pin : src_a;
  assign i_resonator_out_pin = o_resonator_out_pin_oe ? o_resonator_out_pin : src_b;
  clkgen_top clkgen_top_i (
    .i_mclk, .i_rst, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .i_stop_instr,
    .i_main_osc_halt, .i_int_osc_stop, .i_slow_osc_stop, .i_opt_slow_stop_en,
    .i_main_clock_sel, .i_mult_ratio_select, .i_mult_halt, .i_tmr_sel_slow,
    .i_shared_pin_a_dir, .i_shared_pin_a_port, .i_shared_pin_b_dir, .i_shared_pin_b_port,
    .i_resonator_in_pin, .o_resonator_in_pin, .o_resonator_in_pin_oe, .i_resonator_out_pin,
    .o_resonator_out_pin, .o_resonator_out_pin_oe, .o_port_pin_lvl, .o_cpu_tick,
    .o_main_tick, .o_hs_tick, .o_wdt_tick, .o_tmr_tick, .o_amp_gain_high, .o_cpu_hold,
    .o_mult_run, .o_usb_phase);
  clkgen_xtal_model clkgen_xtal_model_i (
    .i_run_a(run_a), .i_run_b(run_b), .o_pad_a(src_a), .o_pad_b(src_b));
  always #5 i_mclk = ~i_mclk;
  //////////////////////////////////////////////////////////////////
  // Tick tallies and the hang guard
  always @(posedge i_mclk) begin
    c_hs += o_hs_tick;
    c_cpu += o_cpu_tick;
    c_main += o_main_tick;
    c_wdt += o_wdt_tick;
    c_tmr += o_tmr_tick;
    c_hold += o_cpu_hold;
    c_ph += o_hs_tick && o_mult_run;
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      final_report;
    end
  end
  task automatic final_report;
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    chk(16'(v >= lo && v <= hi), 16'h0001);
  endtask
  // Register access: one strobe cycle, then data read a cycle later
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_mclk) i_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_mclk) i_rd = 1'b0;
    @(negedge i_mclk) chk(16'(o_rdata), 16'(e));
  endtask
  // Settle the pipelines, then count over n cycles
  task automatic win(input int n);
    repeat (20) @(negedge i_mclk);
    {c_hs, c_cpu, c_wdt, c_tmr, c_hold, c_ph, c_main} = '0;
    repeat (n) @(negedge i_mclk);
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    {i_wr, i_rd, i_stop_instr, i_int_osc_stop, i_slow_osc_stop, i_opt_slow_stop_en} = '0;
    {i_main_clock_sel, i_mult_ratio_select, i_tmr_sel_slow, run_a, run_b} = '0;
    {i_shared_pin_a_dir, i_shared_pin_b_dir, i_addr, i_wdata} = '0;
    {i_shared_pin_a_port, i_shared_pin_b_port, i_mult_halt, i_main_osc_halt} = 4'hf;
    i_rst = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    rd(PM, 8'h00);
    chk(16'({o_resonator_out_pin_oe, o_resonator_in_pin_oe, o_port_pin_lvl}), 16'h000f);
    win(900);
    rng(c_cpu, 149, 151);
    rng(c_wdt, 2, 3);
    rng(c_main, 149, 151);
    rng(c_tmr, 0, 0);
    i_int_osc_stop = 1'b1;
    win(300);
    rng(c_cpu, 0, 0);
    {i_int_osc_stop, i_stop_instr} = 2'h1;
    win(300);
    rng(c_cpu, 0, 0);
    {i_stop_instr, i_slow_osc_stop} = 2'h1;
    win(900);
    rng(c_wdt, 2, 3);
    i_opt_slow_stop_en = 1'b1;
    win(900);
    rng(c_wdt, 0, 0);
    {i_slow_osc_stop, i_opt_slow_stop_en, i_tmr_sel_slow} = 3'h1;
    win(900);
    rng(c_tmr - c_wdt + 9, 9, 9);
    rng(c_tmr, 2, 3);
    wr(PM, 8'h3e);
    rd(PM, 8'h00);
    wr(16'hff9e, 8'hff);
    rd(PM, 8'h00);
    rd(16'hff9e, 8'h00);
    // Mode bits change only with the main oscillator halted
    for (int m = 0; m < 4; m++) begin
      wr(PM, {2'(m), 6'h00});
      rd(PM, {2'(m), 6'h00});
      chk(16'(o_resonator_in_pin_oe), 16'(m != 1));
      // The halted resonator leaves pin b undriven, as the clock input does
      chk(16'(o_resonator_out_pin_oe), 16'(m % 2 == 0));
    end
    wr(PM, 8'h40);
    run_a = 1'b1;
    win(600);
    rng(c_hs, 0, 0);
    {i_main_osc_halt, i_main_clock_sel} = 2'h1;
    win(1000);
    rng(c_hs, 110, 125);
    rng(c_cpu, 110, 125);
    i_stop_instr = 1'b1;
    win(300);
    rng(c_hs, 0, 0);
    i_stop_instr = 1'b0;
    for (int r = 0; r < 2; r++) begin
      i_mult_halt = 1'b1;
      i_mult_ratio_select = 1'(r);
      win(10);
      chk({o_usb_phase[14:0], o_mult_run}, 16'h0000);
      {i_mult_halt, i_main_osc_halt} = 2'h0;
      c_ph = 0;
      repeat (500) @(negedge i_mclk);
      // Freeze the source so the last phase step is tallied before comparing
      i_main_osc_halt = 1'b1;
      repeat (3) @(negedge i_mclk);
      chk(o_usb_phase, 16'(c_ph * (r ? 12 : 8)));
      rng(c_ph, 50, 70);
    end
    {i_mult_halt, i_main_osc_halt, run_a} = 3'h6;
    wr(PM, 8'hc0);
    {i_main_osc_halt, run_b} = 2'h1;
    win(1000);
    rng(c_hs, 110, 125);
    i_main_osc_halt = 1'b1;
    win(300);
    rng(c_hs, 0, 0);
    // The clock mode register resets with the device, back to the fast clock
    {i_rst, i_main_clock_sel} = 2'h2;
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    rd(PM, 8'h00);
    {c_hold, c_cpu} = '0;
    wr(PM, 8'h01);
    repeat (600) @(negedge i_mclk);
    chk(16'(c_hold), 16'(`CLKGEN_AMP_HOLD_CYC));
    rng(c_cpu, 16, 18);
    chk(16'(o_amp_gain_high), 16'h0001);
    rd(PM, 8'h01);
    final_report;
  end
endmodule // testbench
bind clkgen_top clkgen_props #(.PHASE_W(PHASE_W)) clkgen_props_i (
  .i_mclk, .i_rst, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .i_stop_instr,
  .i_main_osc_halt, .i_mult_ratio_select, .i_opt_slow_stop_en, .i_slow_osc_stop,
  .i_shared_pin_a_dir, .i_shared_pin_b_dir, .o_resonator_in_pin_oe, .o_resonator_out_pin_oe,
  .o_cpu_tick, .o_main_tick, .o_hs_tick, .o_wdt_tick, .o_amp_gain_high, .o_cpu_hold,
  .o_mult_run, .o_usb_phase);
`default_nettype wire
